// *** hdl/ncom_top.v ***
/*
 Operating-mode controller of one machining channel, with an AXI4-Lite
 register slave and a level interrupt.
 Assumes all inputs synchronous to CLOCK; BLOCK_DONE is a one-cycle pulse
 from the interpolator, MOTION_IDLE a level from the drives.
*/
// Chosen here: the AXI4-Lite register port and the register addresses.
// Functional notes
// R1: Priority: manual jog, single block, automatic
// R2: Controller requests mode through selection byte
// R3: Active mode reported in check-back byte
// R4: Jog machine function selected and reported
// R5: Per-function check-back bit refreshed every cycle
// R6: Three stop inputs stop axes or spindle
// R7: Reset aborts the active part program
// R8: Reset stops preparation, motion, aux, pointers, alarms
// R9: Channel-reset bit set when reset completes
// R10: Ready bit in mode check-back byte
// R11: Mode change only when channel not active
// R12: Channel reset allows any mode change
// R13: Interrupted channel allows only listed transitions
// R14: Rejected change raises clearable error flag
// R15: Blocked input suppresses mode change requests
// R16: Jog moves by keys, ignores interlocks
// R17: Single block runs one block; automatic whole program
// R18: No valid request keeps current mode
`timescale 1ns/1ps
`include "ncom_defines.vh"

module ncom_top
(
	input wire CLOCK,
	input wire RST_B,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire BLOCK_DONE,
	input wire PROG_END,
	input wire MOTION_IDLE,
	input wire INTERLOCK,
	output reg PREP_RUN,
	output reg FEED_EN,
	output reg MANUAL_SRC,
	output reg AXES_STOP,
	output reg SPINDLE_STOP,
	output reg AUX_SUPPRESS,
	output reg PTR_RESET,
	output reg ALARM_CLR,
	output reg [7:0] AXIS_FUNC,
	output reg IRQ
);

	localparam CH_RESET = 2'h0;
	localparam CH_ACTIVE = 2'h1;
	localparam CH_INTERR = 2'h2;
	localparam CH_RSEQ = 2'h3;

	// Lowest set bit wins, result one-hot
	function [7:0] first_bit;
		input [7:0] v;
		integer i;
		begin
			first_bit = 8'h00;
			for (i = 7; i >= 0; i = i - 1)
				if (v[i])
					first_bit = 8'h01 << i;
		end
	endfunction

	reg [2:0] mode_sel;
	reg [7:0] func_sel;
	reg [4:0] chan_ctrl;
	reg [3:0] irq_stat;
	reg [3:0] irq_mask;
	reg [1:0] mode;
	reg [1:0] origin;
	reg [1:0] chan;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg mode_wr;
	reg start_cmd;
	reg reset_cmd;
	reg [1:0] req_mode;
	reg req_valid;
	reg allowed;
	reg [3:0] ev;
	reg [1:0] stop_cnt;
	wire wr_go;
	wire [2:0] mode_1h;
	wire [7:0] ch_stat;
	wire stop_any;
	wire stop_now;

	assign wr_go = aw_held & w_held & ~S_AXI_BVALID;
	assign mode_1h = (mode == `NCOM_M_JOG) ? 3'h4 : (mode == `NCOM_M_SBE) ? 3'h2 : 3'h1;
	assign ch_stat = {chan == CH_RESET, chan == CH_INTERR, chan == CH_ACTIVE, 5'h00};
	assign stop_any = |chan_ctrl[2:0];
	// Stops that act at once; stop at block end lets the block finish
	assign stop_now = chan_ctrl[`NCOM_B_STOP] | chan_ctrl[`NCOM_B_STOP_AXSP];

	// R1: jog over single block over automatic
	always @*
	begin
		req_valid = |mode_sel;
		if (mode_sel[`NCOM_B_JOG])
			req_mode = `NCOM_M_JOG;
		else if (mode_sel[`NCOM_B_SBE])
			req_mode = `NCOM_M_SBE;
		else
			req_mode = `NCOM_M_AUTO;
	end

	// R12: any change while in channel reset
	always @*
	begin
		allowed = 1'b0;
		case (chan)
			CH_RESET:
				allowed = 1'b1;
			CH_INTERR:
			begin
				// R13: interrupted channel transition table
				if (mode != `NCOM_M_JOG)
					allowed = (req_mode == `NCOM_M_JOG);
				else if (origin == `NCOM_O_AUTO)
					allowed = (req_mode == `NCOM_M_AUTO);
				else if (origin == `NCOM_O_SBE)
					allowed = (req_mode == `NCOM_M_SBE);
			end
			// R11: active channel refuses any change
			CH_ACTIVE:
				allowed = 1'b0;
			default:
				allowed = 1'b0;
		endcase
	end

	// Number of asserted stop inputs
	always @*
	begin
		stop_cnt = {1'b0, chan_ctrl[0]} + {1'b0, chan_ctrl[1]};
		stop_cnt = stop_cnt + {1'b0, chan_ctrl[2]};
	end

	// Bus write channel: address and data taken in either order
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `NCOM_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= ~aw_held & ~(S_AXI_AWVALID & S_AXI_AWREADY);
			S_AXI_WREADY <= ~w_held & ~(S_AXI_WVALID & S_AXI_WREADY);
			if (S_AXI_AWVALID & S_AXI_AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID & S_AXI_WREADY)
			begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (aw_addr <= `NCOM_IRQ_MASK && aw_addr[1:0] == 2'h0
					&& aw_addr != `NCOM_MODE_STAT && aw_addr != `NCOM_FUNC_STAT
					&& aw_addr != `NCOM_CHAN_STAT) ? `NCOM_OKAY : `NCOM_SLVERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `NCOM_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
			if (S_AXI_ARVALID & S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `NCOM_OKAY;
				case (S_AXI_ARADDR)
					`NCOM_MODE_REQ: S_AXI_RDATA <= {29'h0, mode_sel};
					`NCOM_FUNC_REQ: S_AXI_RDATA <= {24'h0, func_sel};
					`NCOM_CHAN_CTRL: S_AXI_RDATA <= {27'h0, chan_ctrl};
					`NCOM_CMD: S_AXI_RDATA <= 32'h00000000;
					// R3: active mode and R10: ready flag
					`NCOM_MODE_STAT: S_AXI_RDATA <= {28'h0, chan != CH_RSEQ, mode_1h};
					`NCOM_FUNC_STAT: S_AXI_RDATA <= {24'h0, AXIS_FUNC};
					`NCOM_CHAN_STAT: S_AXI_RDATA <= {24'h0, ch_stat};
					`NCOM_IRQ_STAT: S_AXI_RDATA <= {28'h0, irq_stat};
					`NCOM_IRQ_MASK: S_AXI_RDATA <= {28'h0, irq_mask};
					default:
					begin
						S_AXI_RDATA <= 32'h00000000;
						S_AXI_RRESP <= `NCOM_SLVERR;
					end
				endcase
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// Software registers and one-cycle command pulses
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			mode_sel <= 3'h0;
			func_sel <= 8'h00;
			chan_ctrl <= 5'h00;
			irq_mask <= `NCOM_MASK_RST;
			mode_wr <= 1'b0;
			start_cmd <= 1'b0;
			reset_cmd <= 1'b0;
		end
		else
		begin
			mode_wr <= 1'b0;
			start_cmd <= 1'b0;
			reset_cmd <= 1'b0;
			if (wr_go)
			begin
				case (aw_addr)
					// R2: mode selection byte written by the PLC
					`NCOM_MODE_REQ:
					begin
						mode_sel <= w_strb[0] ? w_data[2:0] : mode_sel;
						mode_wr <= w_strb[0];
					end
					// R4: machine function selection byte
					`NCOM_FUNC_REQ: func_sel <= w_strb[0] ? w_data[7:0] : func_sel;
					`NCOM_CHAN_CTRL: chan_ctrl <= w_strb[0] ? w_data[4:0] : chan_ctrl;
					`NCOM_CMD:
					begin
						start_cmd <= w_strb[0] & w_data[`NCOM_B_START];
						reset_cmd <= w_strb[0] & w_data[`NCOM_B_RESET];
					end
					`NCOM_IRQ_MASK: irq_mask <= w_strb[0] ? w_data[3:0] : irq_mask;
					default: mode_wr <= 1'b0;
				endcase
			end
		end
	end

	// Mode and channel state machine
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			mode <= `NCOM_MODE_RST;
			origin <= `NCOM_O_NONE;
			chan <= CH_RESET;
			ev <= 4'h0;
		end
		else
		begin
			ev <= 4'h0;
			// R15: blocked input suppresses the request itself
			if (mode_wr & req_valid & ~chan_ctrl[`NCOM_B_BLOCKED] & (req_mode != mode))
			begin
				if (allowed)
				begin
					mode <= req_mode;
					ev[`NCOM_I_MODE_CHG] <= 1'b1;
					if (chan == CH_INTERR && req_mode == `NCOM_M_JOG)
						origin <= (mode == `NCOM_M_SBE) ? `NCOM_O_SBE : `NCOM_O_AUTO;
					else
						origin <= `NCOM_O_NONE;
				end
				else
					// R14: rejection raises the error flag only
					ev[`NCOM_I_MODE_ERR] <= 1'b1;
			end
			// R18: otherwise the active mode stays
			case (chan)
				CH_RESET, CH_INTERR:
					// R16: no program start in jog mode
					if (start_cmd && mode != `NCOM_M_JOG && !stop_any)
						chan <= CH_ACTIVE;
				CH_ACTIVE:
					// R6: stop at block end waits; other stops at once
					if (stop_now)
						chan <= CH_INTERR;
					else if (BLOCK_DONE)
					begin
						// R17: single block ends after one block
						if (mode == `NCOM_M_SBE || PROG_END)
						begin
							chan <= CH_RESET;
							ev[`NCOM_I_PROG_DONE] <= 1'b1;
						end
						else if (chan_ctrl[`NCOM_B_STOP_BEND])
							chan <= CH_INTERR;
					end
				CH_RSEQ:
					// R9: completion once motion has ceased
					if (MOTION_IDLE)
					begin
						chan <= CH_RESET;
						origin <= `NCOM_O_NONE;
						ev[`NCOM_I_RESET_DONE] <= 1'b1;
					end
				default:
					chan <= CH_RESET;
			endcase
			// R7: reset aborts whatever is running
			if (reset_cmd)
				chan <= CH_RSEQ;
		end
	end

	// Channel outputs, all registered
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			PREP_RUN <= 1'b0;
			FEED_EN <= 1'b0;
			MANUAL_SRC <= 1'b0;
			AXES_STOP <= 1'b0;
			SPINDLE_STOP <= 1'b0;
			AUX_SUPPRESS <= 1'b0;
			PTR_RESET <= 1'b0;
			ALARM_CLR <= 1'b0;
			AXIS_FUNC <= 8'h00;
		end
		else
		begin
			// R8: reset halts preparation, motion and aux output
			PREP_RUN <= (chan == CH_ACTIVE) & ~reset_cmd;
			AUX_SUPPRESS <= (chan == CH_RSEQ) | reset_cmd;
			PTR_RESET <= reset_cmd;
			ALARM_CLR <= reset_cmd;
			// R6: one stop halts axes; two or more, or the axes-and-spindle stop, add spindle
			// Stop at block end holds axes only once the block is done
			AXES_STOP <= (chan == CH_RSEQ) | reset_cmd | stop_now
				| ((chan != CH_ACTIVE) & (stop_cnt != 2'h0));
			SPINDLE_STOP <= (chan == CH_RSEQ) | reset_cmd | (stop_cnt >= 2'h2)
				| chan_ctrl[`NCOM_B_STOP_AXSP];
			// R16: jog feeds from keys and ignores interlocks
			MANUAL_SRC <= (mode == `NCOM_M_JOG);
			FEED_EN <= (mode == `NCOM_M_JOG) ? (chan != CH_RSEQ)
				: (chan == CH_ACTIVE) & ~INTERLOCK & ~stop_now;
			// R5: function check-back refreshed every cycle
			AXIS_FUNC <= (mode == `NCOM_M_JOG) ? first_bit(func_sel) : 8'h00;
		end
	end

	// Sticky events, write one to clear, set wins
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			irq_stat <= 4'h0;
			IRQ <= 1'b0;
		end
		else
		begin
			if (wr_go && aw_addr == `NCOM_IRQ_STAT && w_strb[0])
				irq_stat <= (irq_stat & ~w_data[3:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			IRQ <= |(irq_stat & irq_mask);
		end
	end

endmodule

// *** inc/ncom_defines.vh ***
/*
 Constants for the operating-mode controller: register offsets,
 field positions, encodings and reset values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef NCOM_DEFINES_VH
`define NCOM_DEFINES_VH

// Register byte offsets
`define NCOM_MODE_REQ 8'h00
`define NCOM_FUNC_REQ 8'h04
`define NCOM_CHAN_CTRL 8'h08
`define NCOM_CMD 8'h0c
`define NCOM_MODE_STAT 8'h10
`define NCOM_FUNC_STAT 8'h14
`define NCOM_CHAN_STAT 8'h18
`define NCOM_IRQ_STAT 8'h1c
`define NCOM_IRQ_MASK 8'h20

// Mode request / check-back bits
`define NCOM_B_AUTO 0
`define NCOM_B_SBE 1
`define NCOM_B_JOG 2
`define NCOM_B_READY 3
// Channel control bits
`define NCOM_B_STOP_BEND 0
`define NCOM_B_STOP 1
`define NCOM_B_STOP_AXSP 2
`define NCOM_B_BLOCKED 4
// Command bits
`define NCOM_B_START 0
`define NCOM_B_RESET 7
// Channel status bits
`define NCOM_B_ACTIVE 5
`define NCOM_B_INTERR 6
`define NCOM_B_CHRESET 7
// Interrupt status bits
`define NCOM_I_MODE_ERR 0
`define NCOM_I_RESET_DONE 1
`define NCOM_I_MODE_CHG 2
`define NCOM_I_PROG_DONE 3
`define NCOM_IRQ_W 4

// Mode encodings
`define NCOM_M_AUTO 2'h0
`define NCOM_M_SBE 2'h1
`define NCOM_M_JOG 2'h2
// Origin of an interrupted manual jog
`define NCOM_O_NONE 2'h0
`define NCOM_O_AUTO 2'h1
`define NCOM_O_SBE 2'h2

// Reset values
`define NCOM_MODE_RST 2'h0
`define NCOM_MASK_RST 4'h0

// Bus responses
`define NCOM_OKAY 2'h0
`define NCOM_SLVERR 2'h2

`endif

// *** verif/ncom_sva.sv ***
/*
 Port checker for the mode controller.
 Assumes ncom_top as bind target and one clock domain.
*/
`timescale 1ns/1ps
module ncom_sva_chk
(
	input wire CLOCK,
	input wire RST_B,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire S_AXI_RVALID,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire PREP_RUN,
	input wire FEED_EN,
	input wire MANUAL_SRC,
	input wire AXES_STOP,
	input wire SPINDLE_STOP,
	input wire AUX_SUPPRESS,
	input wire PTR_RESET,
	input wire ALARM_CLR,
	input wire [7:0] AXIS_FUNC
);
	// Everything sampled on the one clock, quiet in reset
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	a_reset_entry: assert property ($rose(AUX_SUPPRESS) |-> PTR_RESET && ALARM_CLR)
		else $error("reset entry without pointer and alarm pulses");
	a_reset_halts: assert property (AUX_SUPPRESS |-> AXES_STOP && SPINDLE_STOP)
		else $error("motion not halted in reset sequence");
	a_ptr_pulse: assert property (PTR_RESET |=> !PTR_RESET)
		else $error("pointer reset longer than one cycle");
	a_spindle_axes: assert property (SPINDLE_STOP |-> AXES_STOP)
		else $error("spindle stopped while axes run");
	a_jog_feed: assert property ((MANUAL_SRC && !AUX_SUPPRESS) [*2] |-> FEED_EN)
		else $error("jog feed blocked");
	a_func_idle: assert property (!MANUAL_SRC [*2] |-> AXIS_FUNC == 8'h00)
		else $error("machine function shown outside jog");
	a_func_single: assert property ($onehot0(AXIS_FUNC))
		else $error("more than one machine function");
	a_mode_still: assert property ($changed(MANUAL_SRC) |-> !$past(PREP_RUN))
		else $error("mode changed while channel active");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");

	// Main scenarios reached
	c_reset_seq: cover property ($rose(AUX_SUPPRESS));
	c_axes_only: cover property (AXES_STOP && !SPINDLE_STOP);
	c_jog_feed: cover property (MANUAL_SRC && FEED_EN);
endmodule

bind ncom_top ncom_sva_chk i_chk (.CLOCK(CLOCK), .RST_B(RST_B),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.PREP_RUN(PREP_RUN), .FEED_EN(FEED_EN), .MANUAL_SRC(MANUAL_SRC), .AXES_STOP(AXES_STOP),
	.SPINDLE_STOP(SPINDLE_STOP), .AUX_SUPPRESS(AUX_SUPPRESS), .PTR_RESET(PTR_RESET),
	.ALARM_CLR(ALARM_CLR), .AXIS_FUNC(AXIS_FUNC));

// *** verif/ncom_motion_model.sv ***
/*
 Behavioural motion side: interpolator and drives.
 Assumes the controller clock and its active-low reset.
*/
`timescale 1ns/1ps
module ncom_motion_model
(
	input wire CLOCK,
	input wire RST_B,
	input wire FEED_EN,
	input wire MANUAL_SRC,
	output wire BLOCK_DONE,
	output wire MOTION_IDLE
);
	reg [3:0] coast;
	reg [2:0] blk;

	// Axes coast 4 cycles after feed drops, so idle is never instant
	always @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			coast <= 4'h0;
			blk <= 3'h0;
		end
		else
		begin
			coast <= FEED_EN ? 4'h0 : (coast == 4'h4 ? coast : coast + 4'h1);
			blk <= (FEED_EN && !MANUAL_SRC) ? blk + 3'h1 : 3'h0;
		end
	end

	// One-cycle block end every 8 feed cycles outside jog
	assign BLOCK_DONE = blk == 3'h7;
	assign MOTION_IDLE = coast == 4'h4;
endmodule

// *** verif/ncom_top_test.sv ***
/*
 Self-checking bench for the mode controller over AXI4-Lite.
 Assumes the motion model on the far side and a 20 MHz clock.
*/
`timescale 1ns/1ps
module ncom_top_test;
	reg CLOCK = 1'b0;
	reg RST_B = 1'b0;
	reg [7:0] awa = 8'h00;
	reg [7:0] ara = 8'h00;
	reg [31:0] wd = 32'h0;
	reg awv = 1'b0;
	reg wv = 1'b0;
	reg bry = 1'b0;
	reg arv = 1'b0;
	reg rry = 1'b0;
	reg lock = 1'b0;
	reg pend = 1'b0;
	reg [31:0] rv;
	reg [1:0] rp;
	reg [1:0] bp;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int k;
	wire awr, wrd, bv, arr, rvl, blk, idle, prep, feed, man, axs, sps, aux, ptr, alm, irq;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	wire [7:0] func;

	ncom_top i_ncom_top (.CLOCK(CLOCK), .RST_B(RST_B), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvl), .S_AXI_RREADY(rry), .BLOCK_DONE(blk),
		.PROG_END(pend), .MOTION_IDLE(idle), .INTERLOCK(lock), .PREP_RUN(prep), .FEED_EN(feed),
		.MANUAL_SRC(man), .AXES_STOP(axs), .SPINDLE_STOP(sps), .AUX_SUPPRESS(aux),
		.PTR_RESET(ptr), .ALARM_CLR(alm), .AXIS_FUNC(func), .IRQ(irq));

	ncom_motion_model i_ncom_motion_model (.CLOCK(CLOCK), .RST_B(RST_B), .FEED_EN(feed),
		.MANUAL_SRC(man), .BLOCK_DONE(blk), .MOTION_IDLE(idle));

	// 50 ns period
	always #25 CLOCK = ~CLOCK;

	task results;
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hang counts as a mismatch
	always @(posedge CLOCK)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			results;
		end
	end

	task chk(input string n, input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask

	// Address and data offered together, each dropped when taken
	task wr(input [7:0] a, input [31:0] d);
		reg da;
		reg dw;
		da = 1'b0;
		dw = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(da && dw))
		begin
			@(posedge CLOCK);
			if (awr && !da)
				awv <= 1'b0;
			if (wrd && !dw)
				wv <= 1'b0;
			da = da | awr;
			dw = dw | wrd;
		end
		do @(posedge CLOCK); while (!bv);
		bp = bresp;
		bry <= 1'b0;
		// Status settles within 2 cycles of the response
		repeat (2) @(posedge CLOCK);
	endtask

	task rd(input [7:0] a);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge CLOCK); while (!arr);
		arv <= 1'b0;
		do @(posedge CLOCK); while (!rvl);
		rv = rdata;
		rp = rresp;
		rry <= 1'b0;
		@(posedge CLOCK);
	endtask

	task rc(input [7:0] a, input [31:0] e, input string n);
		rd(a);
		chk(n, e, rv);
	endtask

	// Wait for the channel to settle back into reset
	task pol;
		rv = 32'h0;
		for (k = 0; k < 40 && rv !== 32'h80; k++)
			rd(8'h18);
	endtask

	initial
	begin
		repeat (5) @(posedge CLOCK);
		RST_B <= 1'b1;
		@(posedge CLOCK);
		rc(8'h10, 32'h9, "mode");
		rc(8'h18, 32'h80, "chan");
		wr(8'h1c, 32'hf);
		wr(8'h00, 32'h7);
		rc(8'h10, 32'hc, "mode");
		wr(8'h04, 32'h5);
		rc(8'h14, 32'h1, "func");
		chk("axis", 32'h1, {24'h0, func});
		wr(8'h08, 32'h10);
		wr(8'h00, 32'h1);
		rc(8'h10, 32'hc, "mode");
		rc(8'h1c, 32'h4, "irq");
		wr(8'h08, 32'h0);
		wr(8'h1c, 32'hf);
		wr(8'h00, 32'h1);
		rc(8'h10, 32'h9, "mode");
		wr(8'h1c, 32'hf);
		wr(8'h0c, 32'h1);
		rc(8'h18, 32'h20, "chan");
		chk("run", 32'h6, {29'h0, prep, feed, man});
		// Interlock cuts feed in automatic
		lock <= 1'b1;
		repeat (2) @(posedge CLOCK);
		chk("feed", 32'h0, {31'h0, feed});
		lock <= 1'b0;
		wr(8'h00, 32'h4);
		rc(8'h10, 32'h9, "mode");
		rc(8'h1c, 32'h1, "irq");
		wr(8'h20, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h1c, 32'h1);
		rc(8'h18, 32'h20, "chan");
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h08, 32'h2);
		rc(8'h18, 32'h40, "chan");
		chk("stop", 32'h1, {30'h0, sps, axs});
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h4);
		rc(8'h10, 32'hc, "mode");
		// Jog ignores the interlock
		lock <= 1'b1;
		repeat (2) @(posedge CLOCK);
		chk("feed", 32'h1, {31'h0, feed});
		lock <= 1'b0;
		wr(8'h00, 32'h2);
		rc(8'h10, 32'hc, "mode");
		wr(8'h00, 32'h1);
		rc(8'h10, 32'h9, "mode");
		wr(8'h1c, 32'hf);
		wr(8'h0c, 32'h80);
		pol;
		rc(8'h18, 32'h80, "chan");
		rc(8'h1c, 32'h2, "irq");
		wr(8'h1c, 32'hf);
		wr(8'h00, 32'h2);
		rc(8'h10, 32'ha, "mode");
		wr(8'h0c, 32'h1);
		pol;
		rc(8'h1c, 32'hc, "irq");
		wr(8'h00, 32'h1);
		wr(8'h0c, 32'h1);
		wr(8'h08, 32'h1);
		// Block in flight finishes before the stop takes hold
		repeat (8) @(posedge CLOCK);
		rc(8'h18, 32'h40, "chan");
		chk("stop", 32'h1, {30'h0, sps, axs});
		wr(8'h08, 32'h4);
		chk("stop", 32'h3, {30'h0, sps, axs});
		wr(8'h08, 32'h0);
		// Automatic runs until the last block
		pend <= 1'b1;
		wr(8'h1c, 32'hf);
		wr(8'h0c, 32'h1);
		pol;
		rc(8'h1c, 32'h8, "irq");
		rc(8'h24, 32'h0, "unmapped");
		chk("rresp", 32'h2, {30'h0, rp});
		wr(8'h10, 32'h0);
		chk("bresp", 32'h2, {30'h0, bp});
		results;
	end
endmodule
